// >>> hw/strain_pp_pkg.sv
// Package for the strain result post-processor: register map, field
// positions, reset values, fixed-point scaling and carrier types.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package strain_pp_pkg;

  // ----------------------------------------------------------------
  // Sizes and fixed-point scaling
  // ----------------------------------------------------------------
  localparam int          DATA_W       = 24;
  localparam int          BRIDGES      = 4;
  localparam int          NUM_CFG      = 16;
  localparam int          NUM_RES      = BRIDGES + 1;
  localparam int          FRAC_W       = 20;             // Gain, drift and parallel resistor factors are signed Q4.20
  localparam logic [23:0] ONE_Q        = 24'h10_0000;    // 1.0 in Q4.20
  localparam int          SUPPLY_SHIFT = 21;             // Supply term scaled by 2^21
  localparam logic [31:0] SUPPLY_ONE   = 32'h0020_0000;  // 1.0 at that scale
  localparam int          DIV_W        = 48;
  localparam logic [5:0]  DIV_STEPS    = 6'h30;          // One quotient bit per cycle

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_BASE     = 8'h00;          // Config word n at 4*n
  localparam logic [7:0]  RES_BASE     = 8'h40;          // Results 0..3, then sum
  localparam logic [7:0]  STATUS_ADDR  = 8'h54;

  // Configuration word indices
  localparam int          CFG_MODE_WORD   = 1;
  localparam int          CFG_GAIN_WORD0  = 4;           // Words 4..7
  localparam int          CFG_PAR_WORD    = 7;
  localparam int          CFG_TKG_WORD    = 8;
  localparam int          CFG_TKO_WORD    = 9;
  localparam int          CFG_SUPPLY_WORD = 10;

  // Bit positions in the mode word
  localparam int          BIT_DRIFT_EN    = 6;
  localparam int          BIT_SRC_SEL     = 8;
  localparam int          BIT_TKPAR_EN    = 11;
  localparam int          BIT_FACTOR_EN   = 12;
  localparam int          BIT_SUPPLY_EN   = 13;
  localparam int          BIT_AUTOSTART   = 14;

  // Reset values
  localparam logic [23:0] CFG_RESET           = 24'h00_0000;
  localparam logic [23:0] SUPPLY_FACTOR_RESET = 24'h00_00f7;

  // Status fields
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_COUNT_LSB = 8;

  // ----------------------------------------------------------------
  // Carrier types and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [BRIDGES-1:0][DATA_W-1:0] half_bridge_result;
    logic [DATA_W-1:0]              span_value;
    logic [DATA_W-1:0]              temperature;
    logic [15:0]                    supply_voltage_value;
  } meas_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PAR_DIV,
    ST_DRIFT,
    ST_BRIDGE_SCALE,
    ST_SUPPLY_DIV,
    ST_STORE
  } pp_state_e;

endpackage

// >>> hw/strain_result_postprocessor.sv
// Post-processing datapath: corrects the raw half-bridge results of a
// finished measurement and stores calibrated results for software.
// Assumes measurement_done is a one-cycle pulse with meas stable in that
// cycle, and an Avalon-MM master that holds requests while waitrequest.
//
// Contract
// - Post-process each finished measurement into result registers; one arriving while busy is dropped
// - Start user program only if autostart set
// - Each half-bridge scaled by own gain factor
// - Gain factors are 24-bit, config words 4-7
// - Parallel resistor only when word 1 bit 11
// - Parallel resistor from word 7, signed -8..+7.999
// - Supply correction only when its enable is 1
// - Divide by one plus supply times factor / 2^21
// - Supply correction factor defaults to hex F7
// - Span resistor separate, or internal temperature instead
// - Span compensation leaves offset alone; offset separate
// - Drift compensation only when word 1 bit 6
// - Gain drift word 8, offset drift word 9
// - Word 1 bit 8 selects internal temperature
`timescale 1ns/1ps

module strain_result_postprocessor
  import strain_pp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        measurement_done,
  input  wire meas_s       meas,
  output logic             busy,
  output logic             result_valid,
  output logic             user_program_start
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NUM_CFG-1:0][23:0] cfg_r,    cfg_nxt;
  logic [NUM_RES-1:0][23:0] result_r, result_nxt;
  logic [31:0]              rdata_r,  rdata_nxt;
  logic                     wait_r,   wait_nxt;
  pp_state_e                state_r,  state_nxt;
  meas_s                    meas_r,   meas_nxt;
  logic [BRIDGES-1:0][23:0] work_r,   work_nxt;
  logic [23:0]              comp_r,   comp_nxt;
  logic [23:0]              gain_r,   gain_nxt;
  logic [23:0]              off_r,    off_nxt;
  logic [1:0]               idx_r,    idx_nxt;
  logic [7:0]               count_r,  count_nxt;
  logic                     busy_r,   busy_nxt;
  logic                     valid_r,  valid_nxt;
  logic                     ustart_r, ustart_nxt;
  logic [DIV_W-1:0]         quo_r,    quo_nxt;
  logic [31:0]              rem_r,    rem_nxt;
  logic [31:0]              dmag_r,   dmag_nxt;
  logic [5:0]               dcnt_r,   dcnt_nxt;
  logic                     dneg_r,   dneg_nxt;

  logic                     div_start;
  logic signed [DIV_W-1:0]  div_num;
  logic signed [31:0]       div_den;
  logic [DIV_W-1:0]         div_q;

  // Mode bits
  logic [23:0] mode_w;
  logic        drift_en;
  logic        src_sel;
  logic        tkpar_en;
  logic        hbf_en;
  logic        sup_en;
  logic        autostart;

  assign mode_w    = cfg_r[CFG_MODE_WORD];
  assign drift_en  = mode_w[BIT_DRIFT_EN];
  assign src_sel   = mode_w[BIT_SRC_SEL];
  assign tkpar_en  = mode_w[BIT_TKPAR_EN];
  assign hbf_en    = mode_w[BIT_FACTOR_EN];
  assign sup_en    = mode_w[BIT_SUPPLY_EN];
  assign autostart = mode_w[BIT_AUTOSTART];

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  // Every access sees waitrequest high for one edge; readdata is loaded at
  // that edge so it stands when waitrequest drops. Writes land at the edge
  // where waitrequest is sampled low, matching the master's contract.
  always_comb
  begin
    logic [5:0] widx;
    widx       = avs_address[7:2];
    cfg_nxt    = cfg_r;
    rdata_nxt  = rdata_r;
    wait_nxt   = 1'b1;
    if ((avs_read || avs_write) && wait_r)
    begin
      wait_nxt  = 1'b0;
      rdata_nxt = 32'h0000_0000;
      if (avs_address < RES_BASE)
        rdata_nxt = {8'h00, cfg_r[widx[3:0]]};
      else if (avs_address < STATUS_ADDR)
        rdata_nxt = {8'h00, result_r[3'(widx - RES_BASE[7:2])]};
      else if (avs_address == STATUS_ADDR)
      begin
        rdata_nxt[STAT_BUSY_BIT]                  = busy_r;
        rdata_nxt[STAT_COUNT_LSB +: 8]            = count_r;
      end
    end
    if (avs_write && !wait_r && avs_address < RES_BASE)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (avs_byteenable[b])
          cfg_nxt[widx[3:0]][8*b +: 8] = avs_writedata[8*b +: 8];
      end
    end
  end

  // Config words reset to zero except the supply factor default
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CFG; i++)
        cfg_r[i] <= (i == CFG_SUPPLY_WORD) ? SUPPLY_FACTOR_RESET : CFG_RESET;
      rdata_r <= 32'h0000_0000;
      wait_r  <= 1'b1;
    end
    else
    begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
      wait_r  <= wait_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;

  // ----------------------------------------------------------------
  // Shared restoring divider
  // ----------------------------------------------------------------
  // One divider serves both the parallel resistor and the supply term;
  // this trades 48 cycles per division for a single wide subtractor.
  // A zero divisor yields an all-ones magnitude rather than hanging.
  always_comb
  begin
    logic [32:0] shifted;
    logic [DIV_W-1:0] nabs;
    shifted  = {rem_r, quo_r[DIV_W-1]};
    nabs     = div_num[DIV_W-1] ? DIV_W'(-div_num) : DIV_W'(div_num);
    quo_nxt  = quo_r;
    rem_nxt  = rem_r;
    dmag_nxt = dmag_r;
    dcnt_nxt = dcnt_r;
    dneg_nxt = dneg_r;
    if (div_start)
    begin
      quo_nxt  = nabs;
      rem_nxt  = 32'h0000_0000;
      dmag_nxt = div_den[31] ? 32'(-div_den) : 32'(div_den);
      dneg_nxt = div_num[DIV_W-1] ^ div_den[31];
      dcnt_nxt = DIV_STEPS;
    end
    else if (dcnt_r != 6'h00)
    begin
      if (shifted >= {1'b0, dmag_r})
      begin
        rem_nxt = 32'(shifted - {1'b0, dmag_r});
        quo_nxt = {quo_r[DIV_W-2:0], 1'b1};
      end
      else
      begin
        rem_nxt = shifted[31:0];
        quo_nxt = {quo_r[DIV_W-2:0], 1'b0};
      end
      dcnt_nxt = dcnt_r - 6'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      quo_r  <= '0;
      rem_r  <= 32'h0000_0000;
      dmag_r <= 32'h0000_0000;
      dcnt_r <= 6'h00;
      dneg_r <= 1'b0;
    end
    else
    begin
      quo_r  <= quo_nxt;
      rem_r  <= rem_nxt;
      dmag_r <= dmag_nxt;
      dcnt_r <= dcnt_nxt;
      dneg_r <= dneg_nxt;
    end
  end

  assign div_q = dneg_r ? DIV_W'(-quo_r) : quo_r;

  // ----------------------------------------------------------------
  // Post-processing sequencer
  // ----------------------------------------------------------------
  // A measurement arriving while busy is dropped; the front end only
  // finishes one measurement per cycle time, far longer than this run.
  always_comb
  begin
    logic signed [47:0] prod;
    logic [23:0]        comp_src;
    logic [23:0]        acc;
    logic [23:0]        sum;
    prod       = '0;
    acc        = 24'h00_0000;
    sum        = 24'h00_0000;
    comp_src   = src_sel ? meas.temperature : meas.span_value;
    state_nxt  = state_r;
    meas_nxt   = meas_r;
    work_nxt   = work_r;
    result_nxt = result_r;
    comp_nxt   = comp_r;
    gain_nxt   = gain_r;
    off_nxt    = off_r;
    idx_nxt    = idx_r;
    count_nxt  = count_r;
    busy_nxt   = busy_r;
    valid_nxt  = 1'b0;
    ustart_nxt = 1'b0;
    div_start  = 1'b0;
    div_num    = '0;
    div_den    = '0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (measurement_done)
        begin
          meas_nxt  = meas;
          comp_nxt  = comp_src;
          busy_nxt  = 1'b1;
          state_nxt = ST_DRIFT;
          if (drift_en && tkpar_en)
          begin
            // Rcomp || (k*Rcomp) = Rcomp*k/(1+k), k signed Q4.20
            div_start = 1'b1;
            div_num   = DIV_W'($signed(comp_src) * $signed(cfg_r[CFG_PAR_WORD]));
            div_den   = 32'($signed(cfg_r[CFG_PAR_WORD])) + 32'($signed(ONE_Q));
            state_nxt = ST_PAR_DIV;
          end
        end
      end
      ST_PAR_DIV:
      begin
        if (dcnt_r == 6'h00)
        begin
          comp_nxt  = div_q[23:0];
          state_nxt = ST_DRIFT;
        end
      end
      ST_DRIFT:
      begin
        gain_nxt = ONE_Q;
        off_nxt  = 24'h00_0000;
        if (drift_en)
        begin
          prod     = $signed(cfg_r[CFG_TKG_WORD]) * $signed(comp_r);
          gain_nxt = ONE_Q + prod[FRAC_W +: 24];
          prod     = $signed(cfg_r[CFG_TKO_WORD]) * $signed(comp_r);
          off_nxt  = prod[FRAC_W +: 24];
        end
        idx_nxt   = 2'b00;
        state_nxt = ST_BRIDGE_SCALE;
      end
      ST_BRIDGE_SCALE:
      begin
        // Gain drift scales the bridge; offset drift is a separate addend
        prod = $signed(meas_r.half_bridge_result[idx_r]) * $signed(gain_r);
        acc  = prod[FRAC_W +: 24] + off_r;
        if (hbf_en)
        begin
          prod = $signed(acc) * $signed(cfg_r[CFG_GAIN_WORD0 + 32'(idx_r)]);
          acc  = prod[FRAC_W +: 24];
        end
        work_nxt[idx_r] = acc;
        if (sup_en)
        begin
          // acc / (1 + supply*factor/2^21) as acc*2^21 / (2^21 + supply*factor)
          div_start = 1'b1;
          div_num   = DIV_W'($signed({acc, {SUPPLY_SHIFT{1'b0}}}));
          div_den   = $signed(SUPPLY_ONE)
                    + 32'($signed({1'b0, meas_r.supply_voltage_value})
                          * $signed(cfg_r[CFG_SUPPLY_WORD][7:0]));
          state_nxt = ST_SUPPLY_DIV;
        end
        else if (idx_r == 2'(BRIDGES - 1))
          state_nxt = ST_STORE;
        else
          idx_nxt = idx_r + 2'b01;
      end
      ST_SUPPLY_DIV:
      begin
        if (dcnt_r == 6'h00)
        begin
          work_nxt[idx_r] = div_q[23:0];
          if (idx_r == 2'(BRIDGES - 1))
            state_nxt = ST_STORE;
          else
          begin
            idx_nxt   = idx_r + 2'b01;
            state_nxt = ST_BRIDGE_SCALE;
          end
        end
      end
      ST_STORE:
      begin
        // Results update together so software never reads a mixed set
        for (int i = 0; i < BRIDGES; i++)
        begin
          result_nxt[i] = work_r[i];
          sum           = sum + work_r[i];
        end
        result_nxt[BRIDGES] = sum;
        count_nxt  = count_r + 8'h01;
        valid_nxt  = 1'b1;
        ustart_nxt = autostart;
        busy_nxt   = 1'b0;
        state_nxt  = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r  <= ST_IDLE;
      meas_r   <= '0;
      work_r   <= '0;
      result_r <= '0;
      comp_r   <= 24'h00_0000;
      gain_r   <= 24'h00_0000;
      off_r    <= 24'h00_0000;
      idx_r    <= 2'b00;
      count_r  <= 8'h00;
      busy_r   <= 1'b0;
      valid_r  <= 1'b0;
      ustart_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      meas_r   <= meas_nxt;
      work_r   <= work_nxt;
      result_r <= result_nxt;
      comp_r   <= comp_nxt;
      gain_r   <= gain_nxt;
      off_r    <= off_nxt;
      idx_r    <= idx_nxt;
      count_r  <= count_nxt;
      busy_r   <= busy_nxt;
      valid_r  <= valid_nxt;
      ustart_r <= ustart_nxt;
    end
  end

  assign busy               = busy_r;
  assign result_valid       = valid_r;
  assign user_program_start = ustart_r;

endmodule

// >>> verification/strain_pp_sva.sv
// Checker for the strain result post-processor: bus handshake timing and
// measurement sequencing as seen at the top-level ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps

module strain_pp_sva
  import strain_pp_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        measurement_done,
  input wire logic        busy,
  input wire logic        result_valid,
  input wire logic        user_program_start
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // Exactly one wait cycle, then waitrequest drops for a single cycle
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
                                 |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // Unmapped reads must not leak stale data
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest
                                    && avs_address[7:2] > STATUS_ADDR[7:2]
                                    |-> avs_readdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:24] == 8'h00)
    else $error("read data upper byte not zero");

  // ----------------------------------------------------------------
  // Measurement sequencing
  // ----------------------------------------------------------------
  busy_start_a: assert property (measurement_done && !busy |=> busy[*6])
    else $error("busy not held for the minimum post-processing run");
  // Longest run is all divisions, well under the bound
  done_bound_a: assert property ($rose(busy) |-> ##[6:300] result_valid)
    else $error("results not stored in time");
  store_end_a: assert property (result_valid |-> !busy && $past(busy))
    else $error("result_valid not at the end of a busy run");
  valid_pulse_a: assert property (result_valid |=> !result_valid)
    else $error("result_valid longer than one cycle");
  start_gate_a: assert property (user_program_start |-> result_valid)
    else $error("user program started without stored results");
endmodule

bind strain_result_postprocessor strain_pp_sva strain_pp_sva_inst
(
  .clk                (clk),
  .reset_n            (reset_n),
  .avs_address        (avs_address),
  .avs_read           (avs_read),
  .avs_write          (avs_write),
  .avs_readdata       (avs_readdata),
  .avs_waitrequest    (avs_waitrequest),
  .measurement_done   (measurement_done),
  .busy               (busy),
  .result_valid       (result_valid),
  .user_program_start (user_program_start)
);

// >>> verification/strain_result_postprocessor_test.sv
// Self-checking bench for the strain result post-processor: register
// access over Avalon-MM and post-processing of single measurements.
// Assumes the package constants and the bound checker.
`timescale 1ns/1ps

module strain_result_postprocessor_test import strain_pp_pkg::*;;
  logic        clk;
  logic        reset_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        measurement_done;
  meas_s       meas;
  logic        busy;
  logic        result_valid;
  logic        user_program_start;
  logic [31:0] rd;
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // Design under test; byte lanes driven so partial writes are covered
  strain_result_postprocessor strain_result_postprocessor_inst
  (
    .clk                (clk),
    .reset_n            (reset_n),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .measurement_done   (measurement_done),
    .meas               (meas),
    .busy               (busy),
    .result_valid       (result_valid),
    .user_program_start (user_program_start)
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard; a full run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access; held until waitrequest is sampled low, data taken there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 100)
      err_total++;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  // One measurement: pulse, latency to result_valid, then read results
  task automatic run(input logic [3:0][23:0] bridge, input logic [23:0] s,
                     input logic [23:0] t, input logic [15:0] u,
                     input logic [3:0][23:0] e, input int lat, input logic ups);
    int          n;
    logic        got_ups;
    logic [23:0] sum;
    @(posedge clk);
    meas             <= {bridge, s, t, u};
    measurement_done <= 1'b1;
    @(posedge clk);
    measurement_done <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (result_valid !== 1'b1 && n < 400);
    got_ups = user_program_start;
    check(32'(n), 32'(lat));
    check({31'h0, got_ups}, {31'h0, ups});
    sum = e[0] + e[1] + e[2] + e[3];
    for (int i = 0; i < 4; i++) rchk(8'h40 + 8'(4 * i), {8'h00, e[i]});
    rchk(8'h50, {8'h00, sum});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset_n          = 1'b0;
    avs_address      = 8'h00;
    avs_read         = 1'b0;
    avs_write        = 1'b0;
    avs_writedata    = 32'h00000000;
    avs_byteenable   = 4'hf;
    measurement_done = 1'b0;
    meas             = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values of all configuration words
    for (int i = 0; i < 16; i++) rchk(8'(4 * i), (i == 10) ? 32'h000000f7 : 32'h0);
    $display("test 1 done");
    // Field width, read-only results, unmapped place
    bus(1'b1, 8'h10, 32'hffffffff);
    rchk(8'h10, 32'h00ffffff);
    bus(1'b1, 8'h40, 32'h00000123);
    rchk(8'h40, 32'h00000000);
    rchk(8'h58, 32'h00000000);
    // Only enabled byte lanes are written
    avs_byteenable <= 4'h2;
    bus(1'b1, 8'h08, 32'h00aabbcc);
    avs_byteenable <= 4'hf;
    rchk(8'h08, 32'h0000bb00);
    $display("test 2 done");
    // All corrections off, drift factor set but drift disabled
    bus(1'b1, 8'h20, 32'h00100000);
    bus(1'b1, 8'h04, 32'h00004000);
    run({24'h000010, 24'hfffff0, 24'h000200, 24'h000100}, 24'h100000, 24'h100000,
        16'h0, {24'h000010, 24'hfffff0, 24'h000200, 24'h000100}, 7, 1'b1);
    rchk(8'h54, 32'h00000100);
    $display("test 3 done");
    // Own gain per half-bridge, autostart off
    bus(1'b1, 8'h04, 32'h00001000);
    bus(1'b1, 8'h10, 32'h00200000);
    bus(1'b1, 8'h14, 32'h00100000);
    bus(1'b1, 8'h18, 32'h00080000);
    bus(1'b1, 8'h1c, 32'h00300000);
    run({4{24'h000100}}, 24'h0, 24'h0, 16'h0,
        {24'h000300, 24'h000080, 24'h000100, 24'h000200}, 7, 1'b0);
    rchk(8'h54, 32'h00000200);
    $display("test 4 done");
    // Drift with temperature source, then with span source
    bus(1'b1, 8'h24, 32'h00000010);
    bus(1'b1, 8'h04, 32'h00000140);
    run({4{24'h000100}}, 24'h200000, 24'h100000, 16'h0, {4{24'h000210}}, 7, 1'b0);
    bus(1'b1, 8'h04, 32'h00000040);
    run({4{24'h000100}}, 24'h200000, 24'h100000, 16'h0, {4{24'h000320}}, 7, 1'b0);
    $display("test 5 done");
    // Virtual parallel resistor of 1.0 halves the compensation input
    bus(1'b1, 8'h24, 32'h00000000);
    bus(1'b1, 8'h1c, 32'h00100000);
    bus(1'b1, 8'h04, 32'h00000940);
    run({{3{24'h000100}}, 24'h000000}, 24'h0, 24'h100000, 16'h0,
        {{3{24'h000180}}, 24'h000000}, 56, 1'b0);
    $display("test 6 done");
    // Gains then supply division; supply term equals 1.0, so halving
    bus(1'b1, 8'h28, 32'h00000040);
    bus(1'b1, 8'h04, 32'h00003000);
    run({{3{24'h000200}}, 24'hfffe00}, 24'h0, 24'h0, 16'h8000,
        {24'h000100, 24'h000080, 24'h000100, 24'hfffe00}, 203, 1'b0);
    $display("test 7 done");
    // Busy shows in status; a second pulse while busy is not taken
    @(posedge clk);
    meas             <= {{4{24'h000200}}, 24'h0, 24'h0, 16'h8000};
    measurement_done <= 1'b1;
    @(posedge clk);
    meas             <= '0;
    @(posedge clk);
    measurement_done <= 1'b0;
    rchk(8'h54, 32'h00000601);
    wait (result_valid === 1'b1);
    rchk(8'h40, 32'h00000200);
    rchk(8'h54, 32'h00000700);
    $display("test 8 done");
    print_verdict();
  end
endmodule
